// [logic/clock_mode_pkg.sv]
// shared types and constants for the clock mode and divider path
// assumes all control inputs come from logic on clk_sys
package clock_mode_pkg;
    // width of every divider factor
    localparam int FACTOR_W = 8;
    // mode request codes as seen on the control input
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_PRESCALE = 2'h1;
    localparam logic [1:0] MODE_MULT = 2'h2;
    localparam logic [1:0] MODE_BASE = 2'h3;
    // reset values of the active configuration
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [7:0] RST_FACTOR = 8'h01;
    localparam logic RST_SYS_HALF = 1'b0;
    // sampler reset: a high pin level is assumed, so a pin that is
    // already high when reset ends is not taken as a rising edge
    localparam logic [2:0] RST_SYNC = 3'h7;
    localparam logic RST_LVL = 1'b1;
    // number of asynchronous clock pins sampled
    localparam int PIN_N = 2;
    localparam int PIN_OSC = 0;
    localparam int PIN_LOOP = 1;

    // one-hot path state of the active configuration
    typedef enum logic [3:0] {
        ST_DIRECT = 4'h1,
        ST_PRESCALE = 4'h2,
        ST_MULT = 4'h4,
        ST_BASE = 4'h8
    } path_t;

    // a complete clock configuration
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] p_factor;
        logic [7:0] n_factor;
        logic [7:0] k_factor;
        logic sys_half;
    } clk_cfg_t;
endpackage

// [logic/tick_divider.sv]
// divides a stream of one-cycle ticks by a programmable factor
// assumes tick_in is a single-cycle strobe on clk_sys
`timescale 1ns/10ps
module tick_divider (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // ticks and control
    input wire logic tick_in,
    input wire logic restart,
    input wire logic [7:0] factor,
    // divided strobe
    output logic tick_out
);
    logic [7:0] cnt_q; // ticks seen in the current period
    logic [7:0] last; // terminal count, zero treated as one

    // a factor of zero would never wrap, so it acts as one
    assign last = (factor == 8'h00) ? 8'h00 : factor - 8'h01;
    assign tick_out = tick_in && (cnt_q == last);

    // period counter, cleared on restart so a new factor starts clean
    always_ff @(posedge clk_sys) begin
        if (!rst_b || restart) begin
            cnt_q <= 8'h00;
        end else if (tick_out) begin
            cnt_q <= 8'h00;
        end else if (tick_in) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // tick_divider

// [logic/clock_mode_divider_path.sv]
// clock mode selection and divider path for cpu and system clocks
// assumes oscillator and loop oscillator arrive as asynchronous pins,
// sampled on clk_sys, which must run well above both
`timescale 1ns/10ps
module clock_mode_divider_path (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // asynchronous clock pins
    input wire logic oscillator_clock,
    input wire logic loop_osc_clock,
    // requested configuration
    input wire clock_mode_pkg::clk_cfg_t cfg_req,
    // derived clocks
    output logic cpu_clk,
    output logic system_clock,
    // loop control toward the analogue loop
    output logic ref_pulse,
    output logic fb_pulse,
    output logic loop_bypass,
    output logic loop_free_run,
    // status
    output logic cfg_busy
);
    logic [2:0] sync_q [clock_mode_pkg::PIN_N]; // three-stage samplers
    logic [clock_mode_pkg::PIN_N-1:0] lvl_q; // filtered pin levels
    logic [clock_mode_pkg::PIN_N-1:0] rise; // filtered rising edges
    logic osc_tick; // oscillator edge strobe
    logic loop_tick; // loop oscillator edge strobe
    clock_mode_pkg::clk_cfg_t cfg_q; // active configuration
    clock_mode_pkg::path_t path_q; // active path
    logic p_tick; // predivider output
    logic n_tick; // feedback divider output
    logic k_in; // postdivider source
    logic k_tick; // postdivider output
    logic cpu_tick; // cpu clock edge strobe
    logic sys_tick; // system clock edge strobe
    logic ph_q; // halving phase
    logic cpu_clk_q; // cpu clock level
    logic sys_clk_q; // system clock level
    logic apply; // take new configuration now
    logic ref_q; // registered reference strobe
    logic fb_q; // registered feedback strobe

    // decode a requested mode code into a path
    function automatic clock_mode_pkg::path_t mode_path(
        input logic [1:0] code
    );
        case (code)
            clock_mode_pkg::MODE_PRESCALE: mode_path = clock_mode_pkg::ST_PRESCALE;
            clock_mode_pkg::MODE_MULT: mode_path = clock_mode_pkg::ST_MULT;
            clock_mode_pkg::MODE_BASE: mode_path = clock_mode_pkg::ST_BASE;
            default: mode_path = clock_mode_pkg::ST_DIRECT;
        endcase
    endfunction

    // pin samplers; only stages two and three feed the filter
    genvar gi;
    generate
        for (gi = 0; gi < clock_mode_pkg::PIN_N; gi++) begin : g_pin
            logic pin; // raw pin for this lane
            assign pin = (gi == clock_mode_pkg::PIN_OSC) ? oscillator_clock
                                                        : loop_osc_clock;
            // shift chain; preset high so the first counted edge
            // always follows a low level that was really seen
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    sync_q[gi] <= clock_mode_pkg::RST_SYNC;
                end else begin
                    sync_q[gi] <= {sync_q[gi][1:0], pin};
                end
            end
            // level accepted only once stages two and three agree
            // a false edge after reset would cut the first cpu pulse
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    lvl_q[gi] <= clock_mode_pkg::RST_LVL;
                end else if (sync_q[gi][1] == sync_q[gi][2]) begin
                    lvl_q[gi] <= sync_q[gi][2];
                end
            end
            assign rise[gi] = (sync_q[gi][1] == sync_q[gi][2])
                              && sync_q[gi][2] && !lvl_q[gi];
        end
    endgenerate

    assign osc_tick = rise[clock_mode_pkg::PIN_OSC];
    assign loop_tick = rise[clock_mode_pkg::PIN_LOOP];

    // predivider always runs on the oscillator
    tick_divider u_p_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick_in(osc_tick),
        .restart(apply),
        .factor(cfg_q.p_factor),
        .tick_out(p_tick)
    );

    // feedback divider brings the loop clock down to the reference
    tick_divider u_n_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick_in(loop_tick),
        .restart(apply),
        .factor(cfg_q.n_factor),
        .tick_out(n_tick)
    );

    // postdivider source: predivided oscillator or loop clock
    always_comb begin
        k_in = 1'b0;
        case (path_q)
            clock_mode_pkg::ST_PRESCALE: k_in = p_tick;
            clock_mode_pkg::ST_MULT: k_in = loop_tick;
            clock_mode_pkg::ST_BASE: k_in = loop_tick;
            default: k_in = 1'b0;
        endcase
    end

    tick_divider u_k_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick_in(k_in),
        .restart(apply),
        .factor(cfg_q.k_factor),
        .tick_out(k_tick)
    );

    // direct mode skips every divider
    assign cpu_tick = (path_q == clock_mode_pkg::ST_DIRECT) ? osc_tick
                                                            : k_tick;
    // halving drops every other cpu edge
    assign sys_tick = cpu_tick && (!cfg_q.sys_half || ph_q);

    // switch only where both clocks fall together, so the last old
    // pulse is whole and the first new one starts from low; a dead
    // source therefore holds off any change until it runs again
    assign apply = sys_tick && sys_clk_q && cpu_clk_q
                   && (cfg_req != cfg_q);

    // active configuration
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_q <= '{mode: clock_mode_pkg::RST_MODE,
                       p_factor: clock_mode_pkg::RST_FACTOR,
                       n_factor: clock_mode_pkg::RST_FACTOR,
                       k_factor: clock_mode_pkg::RST_FACTOR,
                       sys_half: clock_mode_pkg::RST_SYS_HALF};
        end else if (apply) begin
            cfg_q <= cfg_req;
        end
    end

    // active path follows the configuration
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            path_q <= clock_mode_pkg::ST_DIRECT;
        end else if (apply) begin
            path_q <= mode_path(cfg_req.mode);
        end
    end

    // clock levels and halving phase
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cpu_clk_q <= 1'b0;
            sys_clk_q <= 1'b0;
            ph_q <= 1'b0;
        end else if (apply) begin
            cpu_clk_q <= 1'b0;
            sys_clk_q <= 1'b0;
            ph_q <= 1'b0;
        end else if (cpu_tick) begin
            cpu_clk_q <= !cpu_clk_q;
            ph_q <= cfg_q.sys_half ? !ph_q : 1'b0;
            if (sys_tick) begin
                sys_clk_q <= !sys_clk_q;
            end
        end
    end

    // reference and feedback strobes, live only while the loop locks
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ref_q <= 1'b0;
            fb_q <= 1'b0;
        end else begin
            ref_q <= p_tick && (path_q == clock_mode_pkg::ST_MULT);
            fb_q <= n_tick && (path_q == clock_mode_pkg::ST_MULT);
        end
    end

    assign cpu_clk = cpu_clk_q;
    assign system_clock = sys_clk_q;
    assign ref_pulse = ref_q;
    assign fb_pulse = fb_q;
    assign loop_bypass = path_q[0] || path_q[1];
    assign loop_free_run = path_q[3];
    assign cfg_busy = (cfg_req != cfg_q);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_prescale_source: assert property (
        (path_q == clock_mode_pkg::ST_PRESCALE) && cpu_tick |-> p_tick
    ) else $error("prescaler cpu edge without predivider edge");

    a_mult_source: assert property (
        (path_q == clock_mode_pkg::ST_MULT) && n_tick |=> fb_q
    ) else $error("feedback strobe lost in multiplied mode");

    a_base_source: assert property (
        (path_q == clock_mode_pkg::ST_BASE) && cpu_tick
        |-> loop_tick && loop_free_run && !loop_bypass
    ) else $error("base mode edge not from loop clock");

    a_sys_ratio: assert property (
        cpu_tick && !apply && !cfg_q.sys_half
        |=> system_clock == cpu_clk
    ) else $error("system clock not following cpu clock");

    a_direct_path: assert property (
        (path_q == clock_mode_pkg::ST_DIRECT) && osc_tick && !apply
        |=> cpu_clk != $past(cpu_clk)
    ) else $error("direct mode cpu clock missed oscillator edge");

    a_switch_clean: assert property (
        $changed(cfg_q) |-> !cpu_clk && !system_clock && $past(cpu_clk)
    ) else $error("configuration changed outside clock boundary");

    c_mode_switch: cover property (apply ##1 cfg_q.mode == 2'h2);
    c_half_sys: cover property (cfg_q.sys_half && sys_tick);
    c_base_run: cover property (loop_free_run && cpu_tick);
endmodule // clock_mode_divider_path

// [tb/tb_clock_mode_divider_path.sv]
// table-driven bench for the clock mode and divider path
// assumes the design package is compiled first; pins are made here
`timescale 1ns/10ps
module tb_clock_mode_divider_path;
    // one table row: a configuration and the cpu period it should give
    typedef struct {
        clock_mode_pkg::clk_cfg_t c;
        int cpu_per;
    } row_t;
    // clock, reset and pins driven by the bench
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic oscillator_clock = 1'b0;
    logic loop_osc_clock = 1'b0;
    clock_mode_pkg::clk_cfg_t cfg_req = {2'h0, 8'h01, 8'h01, 8'h01, 1'b0};
    // design outputs
    logic cpu_clk, system_clock, ref_pulse, fb_pulse;
    logic loop_bypass, loop_free_run, cfg_busy;
    // bookkeeping
    int n_mismatch = 0;
    int compares = 0;
    int min_hi = 9999; // shortest high phase seen on either clock
    int hi_c = 0;
    int hi_s = 0;
    int oc = 0;
    int lc = 0;
    int per;
    logic rf; // any loop pulse seen while measuring
    row_t rows [8];

    clock_mode_divider_path i_clock_mode_divider_path (
        .clk_sys(clk_sys), .rst_b(rst_b),
        .oscillator_clock(oscillator_clock),
        .loop_osc_clock(loop_osc_clock), .cfg_req(cfg_req),
        .cpu_clk(cpu_clk), .system_clock(system_clock),
        .ref_pulse(ref_pulse), .fb_pulse(fb_pulse),
        .loop_bypass(loop_bypass), .loop_free_run(loop_free_run),
        .cfg_busy(cfg_busy)
    );

    // 100 mhz system clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // oscillator every 16 cycles, loop every 10, both well over 3 per level
    always @(negedge clk_sys) begin
        oc <= (oc == 15) ? 0 : oc + 1;
        lc <= (lc == 9) ? 0 : lc + 1;
        oscillator_clock <= (oc < 8);
        loop_osc_clock <= (lc < 5);
    end

    // high phase monitor; reset cuts a phase, so it is not counted
    always @(negedge clk_sys) begin
        if (!rst_b) begin
            hi_c = 0;
            hi_s = 0;
        end else begin
            if (cpu_clk === 1'b1) hi_c++;
            else begin
                if (hi_c > 0 && hi_c < min_hi) min_hi = hi_c;
                hi_c = 0;
            end
            if (system_clock === 1'b1) hi_s++;
            else begin
                if (hi_s > 0 && hi_s < min_hi) min_hi = hi_s;
                hi_s = 0;
            end
        end
    end

    // verdict and end of run
    task close_out;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one comparison
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // output picked for measurement
    function logic pick(input int w);
        case (w)
            0: return cpu_clk;
            1: return system_clock;
            2: return ref_pulse;
            default: return fb_pulse;
        endcase
    endfunction

    // wait for a level, counting cycles, bounded
    task wl(input int w, input logic v, inout int t);
        while (pick(w) !== v && t < 3000) begin
            @(negedge clk_sys);
            t++;
            rf = rf | ref_pulse | fb_pulse;
        end
    endtask

    // cycles from one rising edge to the next
    task meas(input int w, output int p);
        int t;
        t = 0;
        wl(w, 1'b0, t);
        wl(w, 1'b1, t);
        p = 0;
        rf = 1'b0;
        wl(w, 1'b0, p);
        wl(w, 1'b1, p);
    endtask

    // request a configuration and wait until it is taken
    task apply(input clock_mode_pkg::clk_cfg_t c);
        int t;
        t = 0;
        cfg_req <= c;
        @(negedge clk_sys);
        while (cfg_busy !== 1'b0 && t < 3000) begin
            @(negedge clk_sys);
            t++;
        end
        // a request never taken counts as a mismatch here
        chk("cfg_busy", 1'b0, cfg_busy);
    endtask

    // check periods and loop controls of the active row
    task run(input row_t r);
        logic [7:0] pf;
        logic [7:0] nf;
        pf = (r.c.p_factor == 8'h00) ? 8'h01 : r.c.p_factor;
        nf = (r.c.n_factor == 8'h00) ? 8'h01 : r.c.n_factor;
        meas(0, per);
        chk("cpu_period", r.cpu_per, per);
        chk("loop_pulses", r.c.mode == clock_mode_pkg::MODE_MULT, rf);
        meas(1, per);
        chk("sys_period", r.c.sys_half ? 2 * r.cpu_per : r.cpu_per, per);
        chk("loop_bypass", r.c.mode <= 2'h1, loop_bypass);
        chk("loop_free_run", r.c.mode == 2'h3, loop_free_run);
        if (r.c.mode == clock_mode_pkg::MODE_MULT) begin
            meas(2, per);
            chk("ref_period", 16 * pf, per);
            meas(3, per);
            chk("fb_period", 10 * nf, per);
        end
    endtask

    // main sequence: reset, table, then awkward cases
    initial begin
        rows[0] = '{{clock_mode_pkg::MODE_DIRECT, 8'h01, 8'h01, 8'h01, 1'b0}, 32};
        rows[1] = '{{clock_mode_pkg::MODE_DIRECT, 8'h01, 8'h01, 8'h01, 1'b1}, 32};
        rows[2] = '{{clock_mode_pkg::MODE_PRESCALE, 8'h02, 8'h01, 8'h03, 1'b0}, 192};
        rows[3] = '{{clock_mode_pkg::MODE_PRESCALE, 8'h01, 8'h01, 8'h02, 1'b1}, 64};
        rows[4] = '{{clock_mode_pkg::MODE_MULT, 8'h02, 8'h04, 8'h02, 1'b0}, 40};
        rows[5] = '{{clock_mode_pkg::MODE_BASE, 8'h01, 8'h01, 8'h03, 1'b1}, 60};
        rows[6] = '{{clock_mode_pkg::MODE_MULT, 8'h00, 8'h00, 8'h00, 1'b1}, 20};
        rows[7] = '{{clock_mode_pkg::MODE_BASE, 8'h01, 8'h01, 8'h01, 1'b0}, 20};
        repeat (8) @(negedge clk_sys);
        chk("reset_outs", 7'b0000100, {cpu_clk, system_clock, ref_pulse,
            fb_pulse, loop_bypass, loop_free_run, cfg_busy});
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apply(rows[i].c);
            run(rows[i]);
        end
        // a request replaced before it is taken: the later one wins
        cfg_req <= rows[2].c;
        @(negedge clk_sys);
        apply(rows[4].c);
        run(rows[4]);
        // reset in mid-run, request still pending afterwards
        rst_b <= 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("reset_mid", 7'b0000101, {cpu_clk, system_clock, ref_pulse,
            fb_pulse, loop_bypass, loop_free_run, cfg_busy});
        rst_b <= 1'b1;
        apply(rows[4].c);
        run(rows[4]);
        chk("min_high", 1, min_hi >= 10);
        close_out;
    end

    // watchdog at 50k cycles, far beyond the expected run of under 5k cycles
    initial begin
        #500000;
        n_mismatch++;
        close_out;
    end
endmodule // tb_clock_mode_divider_path
